// ---- design/ubsc_defs.svh ----
`ifndef UBSC_DEFS_SVH
`define UBSC_DEFS_SVH

// ----------------------------------------------------------------
// Status bit positions and timing
// ----------------------------------------------------------------
`define UBSC_TXST_BUSY_BIT 0
`define UBSC_TXST_FULL_BIT 1
`define UBSC_CLK_HZ 100000000
`define UBSC_BAUD_DEFAULT 115200
`define UBSC_DATA_BITS 8
`define UBSC_FIFO_DEPTH 4
`define UBSC_RXERR_OVERRUN_BIT 0
`define UBSC_RXERR_FRAMING_BIT 1
`define UBSC_RXERR_PARITY_BIT 2

`endif

// ---- design/ubsc_pkg.sv ----
package ubsc_pkg;

   typedef enum logic [1:0] {
      UBSC_TX_IDLE = 2'b00,
      UBSC_TX_START = 2'b01,
      UBSC_TX_DATA = 2'b11,
      UBSC_TX_STOP = 2'b10
   } ubsc_tx_state_t;

   typedef enum logic [1:0] {
      UBSC_RX_IDLE = 2'b00,
      UBSC_RX_START = 2'b01,
      UBSC_RX_DATA = 2'b11,
      UBSC_RX_STOP = 2'b10
   } ubsc_rx_state_t;

   typedef struct packed {
      logic tx_buffer_full_flag;
      logic tx_shift_busy_flag;
   } ubsc_tx_status_t;

   typedef struct packed {
      logic parity;
      logic framing;
      logic overrun;
   } ubsc_rx_error_t;

endpackage

// ---- design/ubsc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module ubsc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic push, pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   assign in_ready = (cnt_q != CW'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      wr_d = push ? bump(wr_q) : wr_q;
      rd_d = pop ? bump(rd_q) : rd_q;
      cnt_d = cnt_q + CW'(push) - CW'(pop);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage has no reset; contents are qualified by the count.
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule

`default_nettype wire

// ---- design/ubsc_uart.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ubsc_defs.svh"

// Behaviour
// - Buffer-full flag is bit 1 of the transmit status register.
// - Completion pulse is raised at the end of each transmitted frame.
// - With the buffer unread and the FIFO full, the next byte gives overrun; error status stays set.
// - Receiver checks exactly one stop bit, ignoring any second one.
// - Full/busy pair moves 10, 01, 11, 10, 01 during continuous sending.
module ubsc_uart #(
   parameter int BAUD_DIV = `UBSC_CLK_HZ / `UBSC_BAUD_DEFAULT,
   parameter int FIFO_DEPTH = `UBSC_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] tx_buffer_register,
   input wire logic tx_write,
   output logic [1:0] tx_status_register,
   output logic tx_complete_interrupt,
   output logic txd,
   input wire logic rxd,
   input wire logic parity_enable,
   input wire logic parity_odd,
   output logic [7:0] rx_buffer_register,
   output logic rx_valid,
   output logic rx_ready_interrupt,
   input wire logic rx_read,
   output logic [2:0] rx_error_status_register,
   input wire logic rx_error_read,
   output logic rx_fifo_in_ready
);
   localparam int DW = 16;
   localparam logic [DW-1:0] DIV = DW'(BAUD_DIV - 1);
   localparam logic [DW-1:0] HALF = DW'(BAUD_DIV / 2 - 1);

   // ----------------------------------------------------------------
   // Transmit buffer and shifter
   // ----------------------------------------------------------------
   ubsc_pkg::ubsc_tx_state_t tx_st_q, tx_st_d;
   ubsc_pkg::ubsc_tx_status_t txs_q, txs_d;
   logic [7:0] tbuf_q, tbuf_d, tsh_q, tsh_d;
   logic [DW-1:0] tcnt_q, tcnt_d;
   logic [2:0] tbit_q, tbit_d;
   logic txd_q, txd_d, tdone_q, tdone_d;

   always_comb begin
      tx_st_d = tx_st_q;
      txs_d = txs_q;
      tbuf_d = tbuf_q;
      tsh_d = tsh_q;
      tcnt_d = (tcnt_q == '0) ? DIV : tcnt_q - DW'(1);
      tbit_d = tbit_q;
      txd_d = txd_q;
      tdone_d = 1'b0;
      // A write while full overwrites the held byte; software must wait.
      if (tx_write) begin
         tbuf_d = tx_buffer_register;
         txs_d.tx_buffer_full_flag = 1'b1;
      end
      case (tx_st_q)
         ubsc_pkg::UBSC_TX_IDLE: begin
            txd_d = 1'b1;
            if (txs_q.tx_buffer_full_flag) begin
               tsh_d = tbuf_q;
               txs_d.tx_buffer_full_flag = tx_write;
               txs_d.tx_shift_busy_flag = 1'b1;
               tcnt_d = DIV;
               txd_d = 1'b0;
               tx_st_d = ubsc_pkg::UBSC_TX_START;
            end
         end
         ubsc_pkg::UBSC_TX_START: begin
            if (tcnt_q == '0) begin
               txd_d = tsh_q[0];
               tbit_d = '0;
               tx_st_d = ubsc_pkg::UBSC_TX_DATA;
            end
         end
         ubsc_pkg::UBSC_TX_DATA: begin
            if (tcnt_q == '0) begin
               if (tbit_q == 3'h7) begin
                  txd_d = 1'b1;
                  tx_st_d = ubsc_pkg::UBSC_TX_STOP;
               end else begin
                  tsh_d = {1'b0, tsh_q[7:1]};
                  txd_d = tsh_q[1];
                  tbit_d = tbit_q + 3'h1;
               end
            end
         end
         ubsc_pkg::UBSC_TX_STOP: begin
            if (tcnt_q == '0) begin
               // Busy drops only once the stop bit has fully gone out.
               txs_d.tx_shift_busy_flag = 1'b0;
               tdone_d = 1'b1;
               tx_st_d = ubsc_pkg::UBSC_TX_IDLE;
            end
         end
         default: tx_st_d = ubsc_pkg::UBSC_TX_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_st_q <= ubsc_pkg::UBSC_TX_IDLE;
         txs_q <= '0;
         tbuf_q <= '0;
         tsh_q <= '0;
         tcnt_q <= '0;
         tbit_q <= '0;
         txd_q <= 1'b1;
         tdone_q <= 1'b0;
      end else begin
         tx_st_q <= tx_st_d;
         txs_q <= txs_d;
         tbuf_q <= tbuf_d;
         tsh_q <= tsh_d;
         tcnt_q <= tcnt_d;
         tbit_q <= tbit_d;
         txd_q <= txd_d;
         tdone_q <= tdone_d;
      end
   end

   assign tx_status_register[`UBSC_TXST_FULL_BIT] = txs_q.tx_buffer_full_flag;
   assign tx_status_register[`UBSC_TXST_BUSY_BIT] = txs_q.tx_shift_busy_flag;
   assign tx_complete_interrupt = tdone_q;
   assign txd = txd_q;

   // ----------------------------------------------------------------
   // Receiver
   // ----------------------------------------------------------------
   logic rx_m_q, rx_s_q;
   ubsc_pkg::ubsc_rx_state_t rx_st_q, rx_st_d;
   logic [DW-1:0] rcnt_q, rcnt_d;
   logic [3:0] rbit_q, rbit_d;
   logic [8:0] rsh_q, rsh_d;
   logic rpush_q, rpush_d, rfe_q, rfe_d, rpe_q, rpe_d;
   logic [3:0] nbits;

   assign nbits = parity_enable ? 4'h9 : 4'h8;

   always_comb begin
      rx_st_d = rx_st_q;
      rcnt_d = (rcnt_q == '0) ? DIV : rcnt_q - DW'(1);
      rbit_d = rbit_q;
      rsh_d = rsh_q;
      rpush_d = 1'b0;
      rfe_d = rfe_q;
      rpe_d = rpe_q;
      case (rx_st_q)
         ubsc_pkg::UBSC_RX_IDLE: begin
            if (!rx_s_q) begin
               rcnt_d = HALF;
               rx_st_d = ubsc_pkg::UBSC_RX_START;
            end
         end
         ubsc_pkg::UBSC_RX_START: begin
            if (rcnt_q == '0) begin
               rbit_d = '0;
               rx_st_d = rx_s_q ? ubsc_pkg::UBSC_RX_IDLE : ubsc_pkg::UBSC_RX_DATA;
            end
         end
         ubsc_pkg::UBSC_RX_DATA: begin
            if (rcnt_q == '0) begin
               rsh_d = parity_enable ? {rx_s_q, rsh_q[8:1]} : {1'b0, rx_s_q, rsh_q[7:1]};
               rbit_d = rbit_q + 4'h1;
               if (rbit_q == nbits - 4'h1) begin
                  rx_st_d = ubsc_pkg::UBSC_RX_STOP;
               end
            end
         end
         ubsc_pkg::UBSC_RX_STOP: begin
            // Only one stop bit is sampled; a second one is just idle line.
            if (rcnt_q == '0) begin
               rfe_d = !rx_s_q;
               rpe_d = parity_enable && ((^rsh_q) != parity_odd);
               rpush_d = 1'b1;
               rx_st_d = ubsc_pkg::UBSC_RX_IDLE;
            end
         end
         default: rx_st_d = ubsc_pkg::UBSC_RX_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_m_q <= 1'b1;
         rx_s_q <= 1'b1;
         rx_st_q <= ubsc_pkg::UBSC_RX_IDLE;
         rcnt_q <= '0;
         rbit_q <= '0;
         rsh_q <= '0;
         rpush_q <= 1'b0;
         rfe_q <= 1'b0;
         rpe_q <= 1'b0;
      end else begin
         rx_m_q <= rxd;
         rx_s_q <= rx_m_q;
         rx_st_q <= rx_st_d;
         rcnt_q <= rcnt_d;
         rbit_q <= rbit_d;
         rsh_q <= rsh_d;
         rpush_q <= rpush_d;
         rfe_q <= rfe_d;
         rpe_q <= rpe_d;
      end
   end

   // ----------------------------------------------------------------
   // Receive FIFO and error status
   // ----------------------------------------------------------------
   // A full FIFO stands for a buffer software left unread; the byte is dropped.
   logic [7:0] fdata, rbuf_q, rbuf_d;
   logic fvalid, fin_ready, fpop, rvalid_q, rvalid_d;
   ubsc_pkg::ubsc_rx_error_t err_q, err_d;

   ubsc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .in_valid(rpush_q),
      .in_ready(fin_ready),
      .in_data(rsh_q[7:0]),
      .out_valid(fvalid),
      .out_ready(fpop),
      .out_data(fdata)
   );

   assign fpop = fvalid && (!rvalid_q || rx_read);

   always_comb begin
      rbuf_d = fpop ? fdata : rbuf_q;
      rvalid_d = fpop ? 1'b1 : (rx_read ? 1'b0 : rvalid_q);
      err_d = rx_error_read ? '0 : err_q;
      // Set wins over the read clear; errors persist until read.
      if (rpush_q) begin
         if (!fin_ready) begin
            err_d.overrun = 1'b1;
         end
         if (rfe_q) begin
            err_d.framing = 1'b1;
         end
         if (rpe_q) begin
            err_d.parity = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rbuf_q <= '0;
         rvalid_q <= 1'b0;
         err_q <= '0;
      end else begin
         rbuf_q <= rbuf_d;
         rvalid_q <= rvalid_d;
         err_q <= err_d;
      end
   end

   assign rx_buffer_register = rbuf_q;
   assign rx_valid = rvalid_q;
   assign rx_ready_interrupt = rvalid_q;
   assign rx_error_status_register = err_q;
   assign rx_fifo_in_ready = fin_ready;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_full_on_write;
      @(posedge clk) disable iff (!reset_n) tx_write |=> tx_status_register[1];
   endproperty
   a_full_on_write: assert property (p_full_on_write) else $error("full not set");

   property p_pair_order;
      @(posedge clk) disable iff (!reset_n)
         (tx_status_register == 2'b10) |=> (tx_status_register inside {2'b10, 2'b11, 2'b01});
   endproperty
   a_pair_order: assert property (p_pair_order) else $error("bad flag order");

   property p_done_busy;
      @(posedge clk) disable iff (!reset_n)
         tx_complete_interrupt |-> !tx_status_register[0] && $past(tx_status_register[0]);
   endproperty
   a_done_busy: assert property (p_done_busy) else $error("completion w/o busy end");

   property p_stop_high;
      @(posedge clk) disable iff (!reset_n) tx_complete_interrupt |-> txd && $past(txd);
   endproperty
   a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

   property p_overrun;
      @(posedge clk) disable iff (!reset_n) (rpush_q && !fin_ready) |=> err_q.overrun;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed");

   property p_err_hold;
      @(posedge clk) disable iff (!reset_n)
         (err_q != '0 && !rx_error_read) |=> ((err_q & $past(err_q)) == $past(err_q));
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("error lost");

   property p_one_stop;
      @(posedge clk) disable iff (!reset_n) rpush_q |-> rx_st_q == ubsc_pkg::UBSC_RX_IDLE;
   endproperty
   a_one_stop: assert property (p_one_stop) else $error("extra stop checked");

   property p_status_bit;
      @(posedge clk) disable iff (!reset_n) tx_status_register[1] == txs_q.tx_buffer_full_flag;
   endproperty
   a_status_bit: assert property (p_status_bit) else $error("full bit misplaced");
endmodule

`default_nettype wire

// ---- tb/ubsc_peer.sv ----
`timescale 1ns/1ps
`default_nettype none

module ubsc_peer #(
   parameter int DIV = 16
) (
   input wire logic clk,
   input wire logic txd,
   output logic rxd
);
   logic [7:0] got_q[$];
   logic [7:0] shift;

   // ----------------------------------------------------------------
   // Sender on rxd
   // ----------------------------------------------------------------
   initial rxd = 1'b1;

   // The line idles high, so after the stop bits it rests at one.
   task automatic send(input logic [7:0] b, input logic stop_bit, input int nstop);
      rxd = 1'b0;
      repeat (DIV) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
         rxd = b[i];
         repeat (DIV) @(negedge clk);
      end
      rxd = stop_bit;
      repeat (DIV) @(negedge clk);
      rxd = 1'b1;
      repeat (DIV * nstop) @(negedge clk);
   endtask

   // ----------------------------------------------------------------
   // Receiver on txd
   // ----------------------------------------------------------------
   // A frame whose stop bit is not high is not queued, so the bench sees it missing.
   initial begin
      forever begin
         @(negedge txd);
         repeat (DIV / 2) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge clk);
            shift[i] = txd;
         end
         repeat (DIV) @(posedge clk);
         if (txd === 1'b1) begin
            got_q.push_back(shift);
         end
      end
   end
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
   localparam int DIV = 16;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic tx_write = 1'b0;
   logic rx_read = 1'b0;
   logic rx_error_read = 1'b0;
   logic [1:0] tx_status;
   logic tx_done;
   logic txd;
   logic rxd;
   logic rx_valid;
   logic rx_irq;
   logic fifo_ready;
   logic [7:0] rx_data;
   logic [2:0] rx_err;
   int err_total = 0;
   int total_checks = 0;
   int pulses = 0;

   always #5 clk = ~clk;

   ubsc_uart #(.BAUD_DIV(DIV), .FIFO_DEPTH(4)) i_dut (
      .clk(clk),
      .reset_n(reset_n),
      .tx_buffer_register(tx_data),
      .tx_write(tx_write),
      .tx_status_register(tx_status),
      .tx_complete_interrupt(tx_done),
      .txd(txd),
      .rxd(rxd),
      .parity_enable(1'b0),
      .parity_odd(1'b0),
      .rx_buffer_register(rx_data),
      .rx_valid(rx_valid),
      .rx_ready_interrupt(rx_irq),
      .rx_read(rx_read),
      .rx_error_status_register(rx_err),
      .rx_error_read(rx_error_read),
      .rx_fifo_in_ready(fifo_ready)
   );

   ubsc_peer #(.DIV(DIV)) i_peer (
      .clk(clk),
      .txd(txd),
      .rxd(rxd)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: pick = tx_status[1];
         1: pick = tx_status[0];
         default: pick = rx_valid;
      endcase
   endfunction

   // Completion pulses last one cycle, so they are counted at every falling edge here.
   task automatic wait_on(input int sel, input logic lvl, input int lim);
      int n;
      n = 0;
      while (pick(sel) !== lvl) begin
         @(negedge clk);
         if (tx_done === 1'b1) begin
            pulses++;
         end
         n++;
         if (n > lim) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, pick(sel), lvl);
            complete_run();
         end
      end
   endtask

   task automatic write_tx(input logic [7:0] b);
      @(negedge clk);
      tx_data = b;
      tx_write = 1'b1;
      @(negedge clk);
      tx_write = 1'b0;
   endtask

   task automatic pulse_read(input logic err_side);
      @(negedge clk);
      rx_error_read = err_side;
      rx_read = ~err_side;
      @(negedge clk);
      rx_error_read = 1'b0;
      rx_read = 1'b0;
      @(negedge clk);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic tx_back_to_back;
      pulses = 0;
      write_tx(8'ha5);
      wait_on(0, 1'b1, 4);
      check({6'h00, tx_status}, 8'h02);
      wait_on(0, 1'b0, 4);
      check({6'h00, tx_status}, 8'h01);
      write_tx(8'h5a);
      wait_on(0, 1'b1, 4);
      check({6'h00, tx_status}, 8'h03);
      wait_on(0, 1'b0, DIV * 12);
      check(8'(pulses), 8'h01);
      wait_on(1, 1'b0, DIV * 12);
      check(8'(pulses), 8'h02);
      check({6'h00, tx_status}, 8'h00);
      check(8'(i_peer.got_q.size()), 8'h02);
      check(i_peer.got_q[0], 8'ha5);
      check(i_peer.got_q[1], 8'h5a);
   endtask

   task automatic rx_two_stops;
      i_peer.send(8'h3c, 1'b1, 2);
      wait_on(2, 1'b1, DIV * 4);
      check({5'h00, rx_err}, 8'h00);
      check({7'h00, rx_irq}, 8'h01);
      pulse_read(1'b1);
      check(rx_data, 8'h3c);
      pulse_read(1'b0);
      check({7'h00, rx_valid}, 8'h00);
   endtask

   task automatic rx_overrun;
      i_peer.send(8'h11, 1'b0, 1);
      wait_on(2, 1'b1, DIV * 4);
      check({5'h00, rx_err}, 8'h02);
      for (int i = 0; i < 4; i++) begin
         i_peer.send(8'h20 + 8'(i), 1'b1, 1);
      end
      check({7'h00, fifo_ready}, 8'h00);
      i_peer.send(8'h77, 1'b1, 1);
      check({5'h00, rx_err}, 8'h03);
      pulse_read(1'b1);
      check({5'h00, rx_err}, 8'h00);
      wait_on(2, 1'b1, 8);
      check(rx_data, 8'h11);
      pulse_read(1'b0);
      for (int i = 0; i < 4; i++) begin
         wait_on(2, 1'b1, 8);
         check(rx_data, 8'h20 + 8'(i));
         pulse_read(1'b0);
      end
      repeat (4) @(negedge clk);
      check({7'h00, rx_valid}, 8'h00);
   endtask

   initial begin
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      tx_back_to_back();
      rx_two_stops();
      rx_overrun();
      complete_run();
   end
endmodule

`default_nettype wire
